// ==== hdl/avmd_core.v ====
// Accelerometer vector-magnitude change detector with its registers
// Notes on behaviour
// - With clear-mode 0, a below-threshold sample lowers the counter by one.
// - With clear-mode 1, a below-threshold sample zeroes the counter.
// - Threshold is 13 unsigned bits: high register bits 4..0, low register.
// - Threshold LSB equals one output code of the selected range.
// - Debounce count is an 8-bit register of samples to persist.
// - Outside hybrid mode the counter steps once per output sample.
// - In hybrid mode only every second sample steps the counter.
// - X reference is signed 14 bits: high bits 5..0 and low register.
// - Y reference is signed 14 bits: high bits 5..0 and low register.
// - Z reference is signed 14 bits: high bits 5..0 and low register.
// - Programmed references are used only while the source select is 1.
// - Programmed references share the LSB of the selected range.
// - Event when distance to reference exceeds threshold beyond the count.
// - With source select 0, samples at enable become the references.
// - Hold 0 reloads references on event; hold 1 keeps enable values.
// - Latch 0 makes the flag follow the condition; 1 holds it until read.
`include "avmd_defines.vh"
module avmd_core #(
    parameter AXIS_W = 14,
    parameter THS_W  = 13,
    parameter CNT_W  = 8
) (
    input  wire              clk_in,
    input  wire              reset_n_in,
    input  wire [7:0]        reg_addr_in,
    input  wire [7:0]        reg_wdata_in,
    input  wire              reg_wr_in,
    input  wire              reg_rd_in,
    output reg  [7:0]        reg_rdata_out,
    input  wire              sample_valid_in,
    input  wire [AXIS_W-1:0] sample_x_in,
    input  wire [AXIS_W-1:0] sample_y_in,
    input  wire [AXIS_W-1:0] sample_z_in,
    input  wire              func_enable_in,
    input  wire              ref_from_regs_in,
    input  wire              ref_hold_in,
    input  wire              latch_select_in,
    input  wire              hybrid_mode_in,
    input  wire              int_source_read_in,
    output reg               event_flag_out,
    output reg  [CNT_W-1:0]  debounce_state_out
);

    localparam DIF_W = AXIS_W + 1;
    localparam SQ_W  = 2 * DIF_W;
    localparam SUM_W = SQ_W + 2;
    localparam TSQ_W = 2 * THS_W;

    reg  [7:0]        ths_high;
    reg  [7:0]        ths_low;
    reg  [CNT_W-1:0]  db_count;
    reg  [7:0]        rx_high;
    reg  [7:0]        rx_low;
    reg  [7:0]        ry_high;
    reg  [7:0]        ry_low;
    reg  [7:0]        rz_high;
    reg  [7:0]        rz_low;
    reg  [AXIS_W-1:0] last_x;
    reg  [AXIS_W-1:0] last_y;
    reg  [AXIS_W-1:0] last_z;
    reg  [AXIS_W-1:0] cap_x;
    reg  [AXIS_W-1:0] cap_y;
    reg  [AXIS_W-1:0] cap_z;
    reg               use_regs;
    reg               enable_d;
    reg               hybrid_phase;
    reg               cond_flag;
    reg  [CNT_W-1:0]  db_counter;

    wire [THS_W-1:0]  threshold;
    wire [AXIS_W-1:0] prog_x;
    wire [AXIS_W-1:0] prog_y;
    wire [AXIS_W-1:0] prog_z;
    wire [AXIS_W-1:0] ref_x;
    wire [AXIS_W-1:0] ref_y;
    wire [AXIS_W-1:0] ref_z;
    wire              clear_mode;
    wire              enable_rise;
    wire              step;
    wire              above;
    wire              trigger;
    reg  [DIF_W-1:0]  dx;
    reg  [DIF_W-1:0]  dy;
    reg  [DIF_W-1:0]  dz;
    reg  [SQ_W-1:0]   sq_x;
    reg  [SQ_W-1:0]   sq_y;
    reg  [SQ_W-1:0]   sq_z;
    reg  [TSQ_W-1:0]  ths_prod;
    reg  [SUM_W-1:0]  dist_sq;
    reg  [SUM_W-1:0]  ths_sq;

    assign threshold = {ths_high[`AVMD_THS_HIGH_MSB:0], ths_low};
    assign prog_x = {rx_high[`AVMD_REF_HIGH_MSB:0], rx_low};
    assign prog_y = {ry_high[`AVMD_REF_HIGH_MSB:0], ry_low};
    assign prog_z = {rz_high[`AVMD_REF_HIGH_MSB:0], rz_low};
    assign clear_mode = ths_high[`AVMD_CLR_MODE_BIT];

    assign ref_x = (use_regs && ref_from_regs_in) ? prog_x : cap_x;
    assign ref_y = (use_regs && ref_from_regs_in) ? prog_y : cap_y;
    assign ref_z = (use_regs && ref_from_regs_in) ? prog_z : cap_z;

    assign enable_rise = func_enable_in && !enable_d;

    assign step = func_enable_in && sample_valid_in &&
                  (!hybrid_mode_in || hybrid_phase);

    // Squares avoid a root; sample, reference and threshold share one LSB
    // same units compared
    always @* begin
        dx = {sample_x_in[AXIS_W-1], sample_x_in} -
             {ref_x[AXIS_W-1], ref_x};
        dy = {sample_y_in[AXIS_W-1], sample_y_in} -
             {ref_y[AXIS_W-1], ref_y};
        dz = {sample_z_in[AXIS_W-1], sample_z_in} -
             {ref_z[AXIS_W-1], ref_z};
        // Products get full-width targets; inside a concatenation they
        // would keep only the operand width and lose the upper bits
        sq_x = $signed(dx) * $signed(dx);
        sq_y = $signed(dy) * $signed(dy);
        sq_z = $signed(dz) * $signed(dz);
        dist_sq = {2'b00, sq_x} + {2'b00, sq_y} + {2'b00, sq_z};
        ths_prod = threshold * threshold;
        ths_sq = {{(SUM_W-TSQ_W){1'b0}}, ths_prod};
    end

    assign above = dist_sq > ths_sq;
    // Counter already at the count means the condition outlasted it
    // debounced trigger
    assign trigger = step && above && (db_counter >= db_count);

    // Register writes; unused high bits are not stored
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ths_high <= `AVMD_REG_RESET;
            ths_low  <= `AVMD_REG_RESET;
            db_count <= `AVMD_REG_RESET;
            rx_high  <= `AVMD_REG_RESET;
            rx_low   <= `AVMD_REG_RESET;
            ry_high  <= `AVMD_REG_RESET;
            ry_low   <= `AVMD_REG_RESET;
            rz_high  <= `AVMD_REG_RESET;
            rz_low   <= `AVMD_REG_RESET;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `AVMD_OFS_THS_HIGH: begin
                    ths_high <= reg_wdata_in & `AVMD_THS_HIGH_MASK;
                end
                `AVMD_OFS_THS_LOW: begin
                    ths_low <= reg_wdata_in;
                end
                `AVMD_OFS_DB_COUNT: begin
                    db_count <= reg_wdata_in;
                end
                `AVMD_OFS_REF_X_HIGH: begin
                    rx_high <= reg_wdata_in & `AVMD_REF_HIGH_MASK;
                end
                `AVMD_OFS_REF_X_LOW: begin
                    rx_low <= reg_wdata_in;
                end
                `AVMD_OFS_REF_Y_HIGH: begin
                    ry_high <= reg_wdata_in & `AVMD_REF_HIGH_MASK;
                end
                `AVMD_OFS_REF_Y_LOW: begin
                    ry_low <= reg_wdata_in;
                end
                `AVMD_OFS_REF_Z_HIGH: begin
                    rz_high <= reg_wdata_in & `AVMD_REF_HIGH_MASK;
                end
                `AVMD_OFS_REF_Z_LOW: begin
                    rz_low <= reg_wdata_in;
                end
                default: begin
                end
            endcase
        end
    end

    // Registered read data, one cycle after the read strobe
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= `AVMD_REG_RESET;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `AVMD_OFS_THS_HIGH:   reg_rdata_out <= ths_high;
                `AVMD_OFS_THS_LOW:    reg_rdata_out <= ths_low;
                `AVMD_OFS_DB_COUNT:   reg_rdata_out <= db_count;
                `AVMD_OFS_REF_X_HIGH: reg_rdata_out <= rx_high;
                `AVMD_OFS_REF_X_LOW:  reg_rdata_out <= rx_low;
                `AVMD_OFS_REF_Y_HIGH: reg_rdata_out <= ry_high;
                `AVMD_OFS_REF_Y_LOW:  reg_rdata_out <= ry_low;
                `AVMD_OFS_REF_Z_HIGH: reg_rdata_out <= rz_high;
                `AVMD_OFS_REF_Z_LOW:  reg_rdata_out <= rz_low;
                default:              reg_rdata_out <= `AVMD_REG_RESET;
            endcase
        end
    end

    // Latest sample is kept so enabling between samples still has data
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            last_x       <= {AXIS_W{1'b0}};
            last_y       <= {AXIS_W{1'b0}};
            last_z       <= {AXIS_W{1'b0}};
            enable_d     <= 1'b0;
            hybrid_phase <= 1'b0;
        end else begin
            enable_d <= func_enable_in;
            if (sample_valid_in) begin
                last_x <= sample_x_in;
                last_y <= sample_y_in;
                last_z <= sample_z_in;
            end
            if (!func_enable_in) begin
                hybrid_phase <= 1'b0;
            end else if (sample_valid_in) begin
                hybrid_phase <= !hybrid_phase;
            end
        end
    end

    // Reference capture and reload
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cap_x    <= {AXIS_W{1'b0}};
            cap_y    <= {AXIS_W{1'b0}};
            cap_z    <= {AXIS_W{1'b0}};
            use_regs <= 1'b0;
        end else if (enable_rise) begin
            use_regs <= ref_from_regs_in;
            cap_x    <= last_x;
            cap_y    <= last_y;
            cap_z    <= last_z;
        end else if (trigger && !ref_hold_in) begin
            use_regs <= 1'b0;
            cap_x    <= sample_x_in;
            cap_y    <= sample_y_in;
            cap_z    <= sample_z_in;
        end
    end

    // Debounce counter; never climbs beyond the programmed count
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            db_counter <= `AVMD_CNT_ZERO;
            cond_flag  <= 1'b0;
        end else if (!func_enable_in) begin
            db_counter <= `AVMD_CNT_ZERO;
            cond_flag  <= 1'b0;
        end else if (step) begin
            if (trigger) begin
                cond_flag <= 1'b1;
                if (!ref_hold_in) begin
                    db_counter <= `AVMD_CNT_ZERO;
                end
            end else if (above) begin
                db_counter <= db_counter + `AVMD_CNT_STEP;
            end else begin
                cond_flag <= 1'b0;
                if (clear_mode) begin
                    db_counter <= `AVMD_CNT_ZERO;
                end else if (db_counter != `AVMD_CNT_ZERO) begin
                    db_counter <= db_counter - `AVMD_CNT_STEP;
                end
            end
        end
    end

    // Event flag; a new trigger in the read cycle wins over the clear
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            event_flag_out     <= 1'b0;
            debounce_state_out <= `AVMD_CNT_ZERO;
        end else begin
            debounce_state_out <= db_counter;
            if (latch_select_in) begin
                if (trigger) begin
                    event_flag_out <= 1'b1;
                end else if (int_source_read_in) begin
                    event_flag_out <= 1'b0;
                end
            end else begin
                event_flag_out <= trigger ||
                    (cond_flag && !(step && !above) && func_enable_in);
            end
        end
    end

endmodule

// ==== hdl/avmd_defines.vh ====
// Register offsets, field positions and reset values of the detector
`ifndef AVMD_DEFINES_VH
`define AVMD_DEFINES_VH
`define AVMD_OFS_THS_HIGH   8'h60
`define AVMD_OFS_THS_LOW    8'h61
`define AVMD_OFS_DB_COUNT   8'h62
`define AVMD_OFS_REF_X_HIGH 8'h63
`define AVMD_OFS_REF_X_LOW  8'h64
`define AVMD_OFS_REF_Y_HIGH 8'h65
`define AVMD_OFS_REF_Y_LOW  8'h66
`define AVMD_OFS_REF_Z_HIGH 8'h67
`define AVMD_OFS_REF_Z_LOW  8'h68
`define AVMD_REG_RESET      8'h00
`define AVMD_CLR_MODE_BIT   7
`define AVMD_THS_HIGH_MSB   4
`define AVMD_REF_HIGH_MSB   5
`define AVMD_THS_HIGH_MASK  8'h9F
`define AVMD_REF_HIGH_MASK  8'h3F
`define AVMD_CNT_ZERO       8'h00
`define AVMD_CNT_STEP       8'h01
`endif

// ==== tb/avmd_core_assertions.sv ====
// Port-level assertions for the vector-magnitude detector
module avmd_checker #(
    parameter CNT_W = 8
) (
    input wire logic             clk_in,
    input wire logic             reset_n_in,
    input wire logic [7:0]       reg_addr_in,
    input wire logic [7:0]       reg_wdata_in,
    input wire logic             reg_wr_in,
    input wire logic             reg_rd_in,
    input wire logic [7:0]       reg_rdata_out,
    input wire logic             sample_valid_in,
    input wire logic             func_enable_in,
    input wire logic             latch_select_in,
    input wire logic             int_source_read_in,
    input wire logic             event_flag_out,
    input wire logic [CNT_W-1:0] debounce_state_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    sequence s_wr(a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    sequence s_rd(a);
        reg_rd_in && !reg_wr_in && reg_addr_in == a;
    endsequence
    // A write, one idle cycle, then a read of the same place
    sequence s_wr_rd(a);
        s_wr(a) ##1 !reg_wr_in ##1 s_rd(a);
    endsequence
    a_cnt_rdbk:
        assert property (s_wr_rd(8'h62) |=>
            reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("count readback wrong");
    a_ths_rdbk:
        assert property (s_wr_rd(8'h60) |=>
            reg_rdata_out == ($past(reg_wdata_in, 3) & 8'h9F))
        else $error("threshold high readback wrong");
    a_step_by_one:
        assert property ({1'b0, debounce_state_out} <=
            {1'b0, $past(debounce_state_out)} + 9'h001)
        else $error("debounce counter jumped");
    a_quiet_count:
        assert property (func_enable_in && !sample_valid_in |->
            ##2 $stable(debounce_state_out))
        else $error("counter moved without a sample");
    a_off_count:
        assert property (!func_enable_in |-> ##2 debounce_state_out == 0)
        else $error("counter not cleared while disabled");
    a_flag_cause:
        assert property ($rose(event_flag_out) |->
            $past(sample_valid_in && func_enable_in))
        else $error("flag rose without a sample");
    a_off_clears:
        assert property (!func_enable_in && !latch_select_in |=>
            !event_flag_out)
        else $error("unlatched flag kept while disabled");
    a_latch_hold:
        assert property (latch_select_in && event_flag_out &&
            !int_source_read_in |=> event_flag_out)
        else $error("latched flag dropped without read");
    a_read_clear:
        assert property (latch_select_in && int_source_read_in &&
            !sample_valid_in |=> !event_flag_out)
        else $error("latched flag kept after read");
endmodule

bind avmd_core avmd_checker #(.CNT_W(CNT_W)) avmd_checker_i (.*);

// ==== tb/tb_avmd_core.sv ====
// Self-checking bench for the vector-magnitude detector
module tb_avmd_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        sample_valid_in = 1'b0;
    logic [13:0] sample_x_in = 14'h0000;
    logic [13:0] sample_y_in = 14'h0000;
    logic [13:0] sample_z_in = 14'h0000;
    logic        func_enable_in = 1'b0;
    logic        ref_from_regs_in = 1'b1;
    logic        ref_hold_in = 1'b1;
    logic        latch_select_in = 1'b0;
    logic        hybrid_mode_in = 1'b0;
    logic        int_source_read_in = 1'b0;
    wire  [7:0]  reg_rdata_out;
    wire         event_flag_out;
    wire  [7:0]  debounce_state_out;
    int          error_cnt = 0;
    int          tests_run = 0;

    avmd_core avmd_core_i (.*);

    initial forever #25 clk_in = ~clk_in;

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic flag(logic e);
        chk("event_flag_out", {7'h00, e}, {7'h00, event_flag_out});
    endtask
    task automatic wr(logic [7:0] a, d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        chk("reg_rdata_out", e, reg_rdata_out);
    endtask
    task automatic cfg(logic [7:0] h, l, c);
        wr(8'h60, h);
        wr(8'h61, l);
        wr(8'h62, c);
    endtask
    task automatic mode(logic s, h, l, y);
        @(posedge clk_in);
        ref_from_regs_in <= s;
        ref_hold_in <= h;
        latch_select_in <= l;
        hybrid_mode_in <= y;
    endtask
    task automatic en(logic v);
        @(posedge clk_in);
        func_enable_in <= v;
    endtask
    // Two edges after the sample so the lagging counter copy has landed
    task automatic smp(logic [13:0] x, y = 14'h0000, z = 14'h0000);
        @(posedge clk_in);
        sample_x_in <= x;
        sample_y_in <= y;
        sample_z_in <= z;
        sample_valid_in <= 1'b1;
        @(posedge clk_in);
        sample_valid_in <= 1'b0;
        repeat (2) @(negedge clk_in);
    endtask
    task automatic t_regs;
        logic [7:0] m;
        for (int a = 8'h60; a <= 8'h68; a++) begin
            rd(a[7:0], 8'h00);
            wr(a[7:0], 8'hFF);
            m = (a inside {8'h63, 8'h65, 8'h67}) ? 8'h3F : 8'hFF;
            rd(a[7:0], a == 8'h60 ? 8'h9F : m);
            wr(a[7:0], 8'h00);
        end
        wr(8'h69, 8'h5A);
        rd(8'h69, 8'h00);
        $display("done: registers");
    endtask
    task automatic t_deb(logic clr);
        int n;
        cfg({clr, 7'h00}, 8'h0A, 8'h02);
        en(1'b1);
        for (int i = 0; i < 3; i++) begin
            smp(14'h0014);
            flag(i == 2);
        end
        chk("debounce_state_out", 8'h02, debounce_state_out);
        smp(14'h0000);
        flag(1'b0);
        chk("debounce_state_out", clr ? 8'h00 : 8'h01,
            debounce_state_out);
        n = 0;
        while (event_flag_out !== 1'b1 && n < 8) begin
            smp(14'h0014);
            n++;
        end
        chk("samples_to_event", clr ? 8'h03 : 8'h02, n[7:0]);
        en(1'b0);
        $display("done: debounce");
    endtask
    task automatic t_ths;
        logic [13:0] v [3];
        logic [7:0]  ra;
        int          k;
        cfg(8'h10, 8'h00, 8'h00);
        for (int c = 0; c < 9; c++) begin
            k = c % 3;
            ra = 8'h63 + 8'(2 * (c / 3));
            v = '{3{14'h0000}};
            v[c / 3] = k == 2 ? 14'h1001 : 14'h1000;
            wr(ra, k == 0 ? 8'h3F : 8'h00);
            wr(ra + 8'h01, k == 0 ? 8'hFF : 8'h00);
            en(1'b1);
            smp(v[0], v[1], v[2]);
            flag(k != 1);
            en(1'b0);
        end
        $display("done: threshold");
    endtask
    task automatic t_ref(logic hold);
        mode(1'b0, hold, 1'b0, 1'b0);
        cfg(8'h00, 8'h0A, 8'h00);
        smp(14'h0064);
        en(1'b1);
        smp(14'h0069);
        flag(1'b0);
        smp(14'h0000);
        flag(1'b1);
        smp(14'h0000);
        flag(hold);
        en(1'b0);
        $display("done: reference");
    endtask
    task automatic t_latch;
        mode(1'b1, 1'b1, 1'b1, 1'b0);
        en(1'b1);
        smp(14'h0014);
        smp(14'h0000);
        flag(1'b1);
        @(posedge clk_in);
        int_source_read_in <= 1'b1;
        @(posedge clk_in);
        int_source_read_in <= 1'b0;
        @(negedge clk_in);
        flag(1'b0);
        en(1'b0);
        $display("done: latch");
    endtask
    task automatic t_hyb;
        mode(1'b1, 1'b1, 1'b0, 1'b1);
        cfg(8'h00, 8'h0A, 8'h01);
        en(1'b1);
        for (int i = 0; i < 4; i++) begin
            smp(14'h0014);
            flag(i == 3);
        end
        en(1'b0);
        $display("done: hybrid");
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_deb(1'b0);
        t_deb(1'b1);
        t_ths();
        t_ref(1'b0);
        t_ref(1'b1);
        t_latch();
        t_hyb();
        results();
    end
    // About twenty-seven times the length of the full sequence
    initial begin
        #400000;
        error_cnt++;
        results();
    end
endmodule
